// >>> hw/pwg_top.sv
// Functional notes
// - per-pin owner bits pick generator or GPIO
// - module_on starts time base and generator
// - two-bit override value for high/low outputs
// - override bits drive pins from override value
// - pins stay still until first real edge
// - write lock guards output_control behind unlock keys
// - mode 01 redundant, mode 10 push-pull
// - independent_base_select picks master or own base
// - period applied at boundary unless immediate
// - push-pull alternates correctly across period changes
// - duty latched at boundary unless immediate
// - duty source: own or master duty register
// - duty to zero emits no boundary glitch
// - override sync bit 0 applies next clock
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
module pwg_top
	import pwg_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [pwg_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [pwg_pkg::DAT_W-1:0] wb_dat_i,
	output logic      [pwg_pkg::DAT_W-1:0] wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic                      lock_fuse,
	input  wire logic                      gpio_high_out,
	input  wire logic                      gpio_high_oe_n,
	input  wire logic                      gpio_low_out,
	input  wire logic                      gpio_low_oe_n,
	output logic                           pin_high_out,
	output logic                           pin_high_oe_n,
	output logic                           pin_low_out,
	output logic                           pin_low_oe_n
);
	import pwg_pkg::*;

	logic [CNT_W-1:0] timebase_control, master_period, master_duty, generator_control;
	logic [CNT_W-1:0] generator_duty, phase_offset, generator_period, output_control;
	logic [CNT_W-1:0] next_tbc, next_mper, next_mduty, next_gc, next_gduty, next_phase, next_gper, next_oc;
	pwg_unlock_t      unlock_st, next_unlock_st;
	logic             next_ack;
	logic [DAT_W-1:0] next_dat;
	logic [DAT_W-1:0] status_word;
	logic             fuse_meta, fuse_q;
	logic             wr_commit, oc_writable;

	////////////////////////////////////////////////////////////////
	// byte-lane merge for 16-bit registers in the low half word
	function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old_v, input logic [DAT_W-1:0] new_v,
		input logic [3:0] sel);
		logic [CNT_W-1:0] r;
		r = old_v;
		if (sel[0])
			r[7:0] = new_v[7:0];
		if (sel[1])
			r[15:8] = new_v[15:8];
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////
	// lock fuse is static config from outside this clock: two-stage sync
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			fuse_meta <= 1'b0;
			fuse_q <= 1'b0;
		end
		else
		begin
			fuse_meta <= lock_fuse;
			fuse_q <= fuse_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, writes land on the ack edge
	logic             module_on, master_roll, gen_boundary, gen_armed;
	logic [CNT_W-1:0] mcnt, mper_act;

	always_comb
	begin
		wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
		// unlock is consumed by the first output_control write, so software relocks by design
		oc_writable = !fuse_q || unlock_st == UL_OPEN;
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_tbc = timebase_control;
		next_mper = master_period;
		next_mduty = master_duty;
		next_gc = generator_control;
		next_gduty = generator_duty;
		next_phase = phase_offset;
		next_gper = generator_period;
		next_oc = output_control;
		next_unlock_st = unlock_st;
		if (wr_commit)
		begin
			unique case (wb_adr_i)
				OFS_TIMEBASE_CONTROL:  next_tbc = merge(timebase_control, wb_dat_i, wb_sel_i);
				OFS_MASTER_PERIOD:     next_mper = merge(master_period, wb_dat_i, wb_sel_i);
				OFS_MASTER_DUTY:       next_mduty = merge(master_duty, wb_dat_i, wb_sel_i);
				OFS_GENERATOR_CONTROL: next_gc = merge(generator_control, wb_dat_i, wb_sel_i);
				OFS_GENERATOR_DUTY:    next_gduty = merge(generator_duty, wb_dat_i, wb_sel_i);
				OFS_PHASE_OFFSET:      next_phase = merge(phase_offset, wb_dat_i, wb_sel_i);
				OFS_GENERATOR_PERIOD:  next_gper = merge(generator_period, wb_dat_i, wb_sel_i);
				OFS_OUTPUT_CONTROL:
				begin
					if (oc_writable)
						next_oc = merge(output_control, wb_dat_i, wb_sel_i);
					next_unlock_st = UL_LOCKED;
				end
				OFS_UNLOCK:
				begin
					// key pair must arrive as two back-to-back unlock writes
					if (wb_dat_i[CNT_W-1:0] == UNLOCK_KEY_A)
						next_unlock_st = UL_HALF;
					else if (unlock_st == UL_HALF && wb_dat_i[CNT_W-1:0] == UNLOCK_KEY_B)
						next_unlock_st = UL_OPEN;
					else
						next_unlock_st = UL_LOCKED;
				end
				default:
				begin
					next_unlock_st = unlock_st;
				end
			endcase
		end
		status_word = '0;
		status_word[CNT_W-1:0] = mcnt;
		status_word[ST_HIGH_PIN] = pin_high_out;
		status_word[ST_LOW_PIN] = pin_low_out;
		status_word[ST_UNLOCKED] = unlock_st == UL_OPEN;
		status_word[ST_LOCK_FUSE] = fuse_q;
		// unmapped addresses read zero and still acknowledge
		next_dat = '0;
		unique case (wb_adr_i)
			OFS_TIMEBASE_CONTROL:  next_dat[CNT_W-1:0] = timebase_control;
			OFS_MASTER_PERIOD:     next_dat[CNT_W-1:0] = master_period;
			OFS_MASTER_DUTY:       next_dat[CNT_W-1:0] = master_duty;
			OFS_GENERATOR_CONTROL: next_dat[CNT_W-1:0] = generator_control;
			OFS_GENERATOR_DUTY:    next_dat[CNT_W-1:0] = generator_duty;
			OFS_PHASE_OFFSET:      next_dat[CNT_W-1:0] = phase_offset;
			OFS_GENERATOR_PERIOD:  next_dat[CNT_W-1:0] = generator_period;
			OFS_OUTPUT_CONTROL:    next_dat[CNT_W-1:0] = output_control;
			OFS_STATUS:            next_dat = status_word;
			default:               next_dat = '0;
		endcase
		if (wb_ack_o)
			next_dat = wb_dat_o;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			timebase_control <= RST_ZERO;
			master_period <= RST_PERIOD;
			master_duty <= RST_ZERO;
			generator_control <= RST_ZERO;
			generator_duty <= RST_ZERO;
			phase_offset <= RST_ZERO;
			generator_period <= RST_PERIOD;
			output_control <= RST_ZERO;
			unlock_st <= UL_LOCKED;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			timebase_control <= next_tbc;
			master_period <= next_mper;
			master_duty <= next_mduty;
			generator_control <= next_gc;
			generator_duty <= next_gduty;
			phase_offset <= next_phase;
			generator_period <= next_gper;
			output_control <= next_oc;
			unlock_st <= next_unlock_st;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	////////////////////////////////////////////////////////////////
	// master time base
	logic [CNT_W-1:0] next_mcnt, next_mper_act, mper_use;
	logic             period_imm;

	always_comb
	begin
		module_on = timebase_control[TBC_MODULE_ON];
		period_imm = timebase_control[TBC_PERIOD_IMM];
		mper_use = period_imm ? master_period : mper_act;
		master_roll = module_on & (mcnt >= mper_use);
		// off: nothing to cut, so the first frame after enable already uses the programmed period
		next_mper_act = (period_imm || master_roll || !module_on) ? master_period : mper_act;
		if (!module_on)
			next_mcnt = '0;
		else if (master_roll)
			next_mcnt = '0;
		else
			next_mcnt = mcnt + CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mcnt <= '0;
			mper_act <= RST_PERIOD;
		end
		else
		begin
			mcnt <= next_mcnt;
			mper_act <= next_mper_act;
		end
	end

	////////////////////////////////////////////////////////////////
	// generator; duty source picked here so the latch sees the chosen register
	logic             gen_high, gen_low;
	logic [CNT_W-1:0] duty_src;
	logic             indep_sel;

	assign indep_sel = generator_control[GC_INDEP];
	assign duty_src = generator_control[GC_MASTER_DUTY] ? master_duty : generator_duty;

	pwg_gen #(.W(CNT_W)) u_gen (
		.clk         (clk),
		.resetn      (resetn),
		.module_on   (module_on),
		.indep_sel   (indep_sel),
		.per_cmd     (indep_sel ? generator_period : master_period),
		.per_imm     (period_imm),
		.master_per  (mper_use),
		.master_roll (master_roll),
		.phase       (phase_offset),
		.duty_cmd    (duty_src),
		.duty_imm    (generator_control[GC_DUTY_IMM]),
		.mode        (output_control[OC_MODE_LO +: 2]),
		.out_high    (gen_high),
		.out_low     (gen_low),
		.boundary    (gen_boundary),
		.armed       (gen_armed)
	);

	////////////////////////////////////////////////////////////////
	// override stage and pin ownership mux
	logic       ovr_h_act, ovr_l_act, next_ovr_h, next_ovr_l;
	logic [1:0] ovr_val_act, next_ovr_val;
	logic       next_ph, next_ph_oe_n, next_pl, next_pl_oe_n;

	always_comb
	begin
		// sync bit clear: take new override settings at once, else at the cycle start
		if (!output_control[OC_OVR_SYNC] || gen_boundary)
		begin
			next_ovr_h = output_control[OC_HIGH_OVR];
			next_ovr_l = output_control[OC_LOW_OVR];
			next_ovr_val = output_control[OC_OVR_VAL_LO +: 2];
		end
		else
		begin
			next_ovr_h = ovr_h_act;
			next_ovr_l = ovr_l_act;
			next_ovr_val = ovr_val_act;
		end
		// GPIO owner gets the pin untouched by anything in the generator path
		if (output_control[OC_HIGH_OWNER])
		begin
			next_ph = ovr_h_act ? ovr_val_act[1] : gen_high;
			next_ph_oe_n = 1'b0;
		end
		else
		begin
			next_ph = gpio_high_out;
			next_ph_oe_n = gpio_high_oe_n;
		end
		if (output_control[OC_LOW_OWNER])
		begin
			next_pl = ovr_l_act ? ovr_val_act[0] : gen_low;
			next_pl_oe_n = 1'b0;
		end
		else
		begin
			next_pl = gpio_low_out;
			next_pl_oe_n = gpio_low_oe_n;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ovr_h_act <= 1'b0;
			ovr_l_act <= 1'b0;
			ovr_val_act <= 2'h0;
			pin_high_out <= 1'b0;
			pin_high_oe_n <= 1'b1;
			pin_low_out <= 1'b0;
			pin_low_oe_n <= 1'b1;
		end
		else
		begin
			ovr_h_act <= next_ovr_h;
			ovr_l_act <= next_ovr_l;
			ovr_val_act <= next_ovr_val;
			pin_high_out <= next_ph;
			pin_high_oe_n <= next_ph_oe_n;
			pin_low_out <= next_pl;
			pin_low_oe_n <= next_pl_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_gpio_owner;
		!output_control[OC_HIGH_OWNER] |=> pin_high_out == $past(gpio_high_out) && pin_high_oe_n == $past(gpio_high_oe_n);
	endproperty
	a_gpio_owner: assert property (p_gpio_owner) else $error("generator touched GPIO pin");

	property p_gen_owner;
		output_control[OC_LOW_OWNER] |=> !pin_low_oe_n;
	endproperty
	a_gen_owner: assert property (p_gen_owner) else $error("owned low pin not driven");

	property p_start_count;
		module_on && mcnt == '0 && mper_use != '0 |=> mcnt == CNT_W'(1);
	endproperty
	a_start_count: assert property (p_start_count) else $error("time base failed to start");

	property p_off_zero;
		!module_on |=> mcnt == '0;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("time base ran while off");

	property p_override_high;
		output_control[OC_HIGH_OWNER] && ovr_h_act |=> pin_high_out == $past(ovr_val_act[1]);
	endproperty
	a_override_high: assert property (p_override_high) else $error("override value not driven");

	property p_lock;
		fuse_q && unlock_st != UL_OPEN && wr_commit && wb_adr_i == OFS_OUTPUT_CONTROL
			|=> output_control == $past(output_control);
	endproperty
	a_lock: assert property (p_lock) else $error("locked register was written");

	property p_period_hold;
		!period_imm && !master_roll |=> mper_act == ($past(module_on) ? $past(mper_act) : $past(master_period));
	endproperty
	a_period_hold: assert property (p_period_hold) else $error("period changed off boundary");

	property p_override_now;
		!output_control[OC_OVR_SYNC] |=> ovr_h_act == $past(output_control[OC_HIGH_OVR]);
	endproperty
	a_override_now: assert property (p_override_now) else $error("override not applied next clock");

	property p_ack_drop;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

	c_enable: cover property (!module_on ##1 module_on);
	c_unlock: cover property (unlock_st == UL_HALF ##1 unlock_st == UL_OPEN);
	c_override: cover property (ovr_h_act && ovr_l_act && module_on);
	c_armed: cover property (!gen_armed ##1 gen_armed);
endmodule : pwg_top

// >>> hw/pwg_pkg.sv
package pwg_pkg;
	localparam int CNT_W = 16;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;

	// register byte addresses
	localparam logic [ADR_W-1:0] OFS_TIMEBASE_CONTROL  = 8'h00;
	localparam logic [ADR_W-1:0] OFS_MASTER_PERIOD     = 8'h04;
	localparam logic [ADR_W-1:0] OFS_MASTER_DUTY       = 8'h08;
	localparam logic [ADR_W-1:0] OFS_GENERATOR_CONTROL = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_GENERATOR_DUTY    = 8'h10;
	localparam logic [ADR_W-1:0] OFS_PHASE_OFFSET      = 8'h14;
	localparam logic [ADR_W-1:0] OFS_GENERATOR_PERIOD  = 8'h18;
	localparam logic [ADR_W-1:0] OFS_OUTPUT_CONTROL    = 8'h1c;
	localparam logic [ADR_W-1:0] OFS_UNLOCK            = 8'h20;
	localparam logic [ADR_W-1:0] OFS_STATUS            = 8'h24;

	// timebase_control fields
	localparam int TBC_MODULE_ON  = 15;
	localparam int TBC_PERIOD_IMM = 10;
	// generator_control fields
	localparam int GC_INDEP       = 9;
	localparam int GC_MASTER_DUTY = 8;
	localparam int GC_DUTY_IMM    = 0;
	// output_control fields
	localparam int OC_HIGH_OWNER  = 15;
	localparam int OC_LOW_OWNER   = 14;
	localparam int OC_MODE_LO     = 10;
	localparam int OC_HIGH_OVR    = 9;
	localparam int OC_LOW_OVR     = 8;
	localparam int OC_OVR_VAL_LO  = 6;
	localparam int OC_OVR_SYNC    = 0;
	// status fields
	localparam int ST_HIGH_PIN    = 16;
	localparam int ST_LOW_PIN     = 17;
	localparam int ST_UNLOCKED    = 18;
	localparam int ST_LOCK_FUSE   = 19;

	// output modes
	localparam logic [1:0] MODE_COMPL     = 2'h0;
	localparam logic [1:0] MODE_REDUNDANT = 2'h1;
	localparam logic [1:0] MODE_PUSH_PULL = 2'h2;

	// reset values
	localparam logic [CNT_W-1:0] RST_ZERO   = 16'h0000;
	localparam logic [CNT_W-1:0] RST_PERIOD = 16'h00ff;

	// unlock keys, written in this order to the unlock register
	localparam logic [CNT_W-1:0] UNLOCK_KEY_A = 16'hc3a5;
	localparam logic [CNT_W-1:0] UNLOCK_KEY_B = 16'h3c5a;

	typedef enum logic [1:0] {UL_LOCKED, UL_HALF, UL_OPEN} pwg_unlock_t;
endpackage : pwg_pkg

// >>> hw/pwg_gen.sv
module pwg_gen
	import pwg_pkg::*;
#(
	parameter int W = pwg_pkg::CNT_W
)(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         module_on,
	input  wire logic         indep_sel,
	input  wire logic [W-1:0] per_cmd,
	input  wire logic         per_imm,
	input  wire logic [W-1:0] master_per,
	input  wire logic         master_roll,
	input  wire logic [W-1:0] phase,
	input  wire logic [W-1:0] duty_cmd,
	input  wire logic         duty_imm,
	input  wire logic [1:0]   mode,
	output logic              out_high,
	output logic              out_low,
	output logic              boundary,
	output logic              armed
);
	logic [W-1:0] cnt, per_act, duty_act;
	logic         tog;
	logic [W-1:0] next_cnt, next_per_act, next_duty_act, per_use;
	logic         next_tog, next_armed, next_high, next_low, raw;

	////////////////////////////////////////////////////////////////
	// counter, latched period and duty, push-pull steering
	always_comb
	begin
		per_use = per_imm ? per_cmd : per_act;
		boundary = module_on & (indep_sel ? (cnt >= per_use) : master_roll);
		// while off no cycle runs, so the latch follows the register and enable starts on the new period
		next_per_act = (per_imm || boundary || !module_on) ? per_cmd : per_act;
		// duty latched only at the boundary unless immediate
		next_duty_act = (duty_imm || boundary) ? duty_cmd : duty_act;
		if (!module_on)
			next_cnt = '0;
		else if (boundary)
			next_cnt = indep_sel ? '0 : phase;
		else if (!indep_sel && cnt >= master_per)
			next_cnt = '0;
		else
			next_cnt = cnt + W'(1);
		// one flip per boundary, so a period change can never pair two pulses
		next_tog = module_on & (boundary ? ~tog : tog);
		// pins stay low until the first real cycle start after enable
		next_armed = module_on & (armed | boundary);
		// compare uses the new duty in the boundary cycle: zero duty gives no sliver
		raw = next_cnt < next_duty_act;
		next_high = 1'b0;
		next_low = 1'b0;
		if (next_armed)
		begin
			unique case (mode)
				MODE_REDUNDANT:
				begin
					next_high = raw;
					next_low = raw;
				end
				MODE_PUSH_PULL:
				begin
					next_high = raw & ~next_tog;
					next_low = raw & next_tog;
				end
				default:
				begin
					next_high = raw;
					next_low = ~raw;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cnt <= '0;
			per_act <= RST_PERIOD;
			duty_act <= RST_ZERO;
			tog <= 1'b0;
			armed <= 1'b0;
			out_high <= 1'b0;
			out_low <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			per_act <= next_per_act;
			duty_act <= next_duty_act;
			tog <= next_tog;
			armed <= next_armed;
			out_high <= next_high;
			out_low <= next_low;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_duty_hold;
		module_on && !duty_imm && !boundary |=> duty_act == $past(duty_act);
	endproperty
	a_duty_hold: assert property (p_duty_hold) else $error("duty changed off boundary");

	property p_no_zero_pulse;
		duty_act == '0 |-> !out_high;
	endproperty
	a_no_zero_pulse: assert property (p_no_zero_pulse) else $error("pulse with zero duty");

	property p_master_count;
		module_on && !indep_sel && !master_roll && cnt < master_per |=> cnt == $past(cnt) + W'(1);
	endproperty
	a_master_count: assert property (p_master_count) else $error("master-based count broke");

	property p_quiet_unarmed;
		!armed |-> !out_high && !out_low;
	endproperty
	a_quiet_unarmed: assert property (p_quiet_unarmed) else $error("output before first cycle");

	property p_pp_exclusive;
		mode == MODE_PUSH_PULL ##1 mode == MODE_PUSH_PULL |-> !(out_high && out_low);
	endproperty
	a_pp_exclusive: assert property (p_pp_exclusive) else $error("push-pull drove both");

	c_pp_boundary: cover property (mode == MODE_PUSH_PULL && boundary && armed);
endmodule : pwg_gen

// >>> verif/pwg_gate_model.sv
module pwg_gate_model
(
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      gate_on
);
	timeunit 1ns;
	timeprecision 1ps;

	// a released pin falls to the pull-down, so the power switch stays off instead of floating
	assign gate_on = pin_oe_n ? 1'b0 : pin_out;
endmodule : pwg_gate_model

// >>> verif/tb_pwg_top.sv
module tb_pwg_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pwg_pkg::*;

	logic        clk    = 1'b0;
	logic        resetn = 1'b0;
	logic        cyc    = 1'b0;
	logic        stb    = 1'b0;
	logic        we     = 1'b0;
	logic        fuse   = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [3:0]  sel    = 4'h0;
	logic [31:0] wdat   = 32'h0000_0000;
	logic [31:0] q;
	logic [31:0] rd_o;
	logic        ack_o;
	logic        gh     = 1'b0;
	logic        ghn    = 1'b1;
	logic        gl     = 1'b0;
	logic        gln    = 1'b1;
	logic        ph, phn, pl, pln, gate_h, gate_l;
	int          n_errors = 0;
	int          n_checks = 0;
	int          hc, lc, r;
	int          eh [4] = '{8, 8, 4, 8};
	int          el [4] = '{12, 8, 4, 12};

	always #2.5 clk = ~clk;

	pwg_top i_pwg_top (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack_o),
		.lock_fuse(fuse), .gpio_high_out(gh), .gpio_high_oe_n(ghn), .gpio_low_out(gl),
		.gpio_low_oe_n(gln), .pin_high_out(ph), .pin_high_oe_n(phn), .pin_low_out(pl),
		.pin_low_oe_n(pln));
	pwg_gate_model i_gate_high (.pin_out(ph), .pin_oe_n(phn), .gate_on(gate_h));
	pwg_gate_model i_gate_low (.pin_out(pl), .pin_oe_n(pln), .gate_on(gate_l));

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one classic cycle: request held until ack is sampled, then one idle cycle
	task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'hf;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (ack_o !== 1'b1 && i < 40);
		q = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 40)
		begin
			n_errors++;
			stop_test();
		end
		@(posedge clk);
	endtask : wbx

	// counts switch-on cycles after a settling wait
	task automatic watch(input int pre, input int n);
		repeat (pre) @(posedge clk);
		hc = 0;
		lc = 0;
		repeat (n)
		begin
			@(posedge clk);
			hc += int'(gate_h === 1'b1);
			lc += int'(gate_l === 1'b1);
		end
	endtask : watch

	// switch-on cycles that a window of whole frames holds for a given on time per frame
	function automatic int on_count(input int duty, input int frame, input int win);
		return duty * (win / frame);
	endfunction : on_count

	////////////////////////////////////////////////////////////////////////////
	// main sequence: period 9 gives ten-cycle frames, duty 4
	initial
	begin
		r = $urandom(15);
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		wbx(0, OFS_MASTER_PERIOD, 0);
		chk("period reset", q, {16'h0000, RST_PERIOD});
		wbx(0, OFS_OUTPUT_CONTROL, 0);
		chk("owner reset", q, 32'h0000_0000);
		wbx(0, 8'h3c, 0);
		chk("unmapped", q, 32'h0000_0000);
		repeat (8)
		begin
			r = $urandom;
			gh <= r[0];
			ghn <= r[1];
			gl <= r[2];
			gln <= r[3];
			repeat (3) @(posedge clk);
			chk("high pin", {ph, phn}, {r[0], r[1]});
			chk("low pin", {pl, pln}, {r[2], r[3]});
		end
		ghn <= 1'b1;
		gln <= 1'b1;
		repeat (6)
		begin
			r = $urandom;
			wbx(1, OFS_MASTER_DUTY, r);
			wbx(0, OFS_MASTER_DUTY, 0);
			chk("master duty", q, {16'h0000, r[15:0]});
		end
		wbx(1, OFS_MASTER_PERIOD, 9);
		wbx(1, OFS_GENERATOR_DUTY, 4);
		wbx(1, OFS_MASTER_DUTY, 2);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_0300);
		wbx(1, OFS_TIMEBASE_CONTROL, 32'h0000_8000);
		wbx(1, OFS_OUTPUT_CONTROL, 0);
		repeat (20) @(posedge clk);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c000);
		for (int v = 0; v < 4; v++)
		begin
			wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c300 | (v << 6));
			watch(4, 20);
			chk("override high", hc, v[1] * 20);
			chk("override low", lc, v[0] * 20);
		end
		for (int m = 0; m < 4; m++)
		begin
			wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c000 | (m << 10));
			watch(24, 20);
			chk("mode high", hc, eh[m]);
			chk("mode low", lc, el[m]);
		end
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c800);
		wbx(1, OFS_MASTER_PERIOD, 11);
		watch(40, 24);
		chk("push-pull high", hc, 4);
		chk("push-pull low", lc, 4);
		wbx(1, OFS_MASTER_PERIOD, 9);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c400);
		wbx(1, OFS_GENERATOR_DUTY, 0);
		watch(30, 20);
		chk("zero duty", hc + lc, 0);
		wbx(1, OFS_GENERATOR_CONTROL, 32'h0000_0100);
		watch(30, 20);
		chk("master source", hc + lc, 8);
		wbx(1, OFS_GENERATOR_CONTROL, 0);
		wbx(1, OFS_GENERATOR_DUTY, 4);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c000);
		wbx(1, OFS_TIMEBASE_CONTROL, 0);
		wbx(0, OFS_STATUS, 0);
		chk("count off", q[15:0], 0);
		wbx(1, OFS_TIMEBASE_CONTROL, 32'h0000_8000);
		watch(0, 6);
		chk("quiet start", hc + lc, 0);
		watch(20, 20);
		chk("run high", hc, 8);
		// own time base: five-cycle frames, duty 4, complementary
		wbx(1, OFS_GENERATOR_PERIOD, 4);
		wbx(1, OFS_GENERATOR_CONTROL, 32'h0000_0200);
		watch(30, 20);
		chk("own base high", hc, on_count(4, 5, 20));
		chk("own base low", lc, on_count(1, 5, 20));
		// restart with immediate duty and immediate period, then push-pull on five-cycle frames
		wbx(1, OFS_TIMEBASE_CONTROL, 0);
		wbx(1, OFS_GENERATOR_CONTROL, 32'h0000_0001);
		wbx(1, OFS_TIMEBASE_CONTROL, 32'h0000_8400);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c800);
		wbx(1, OFS_MASTER_PERIOD, 4);
		wbx(1, OFS_GENERATOR_DUTY, 2);
		watch(30, 20);
		chk("immediate high", hc, on_count(2, 10, 20));
		chk("immediate low", lc, on_count(2, 10, 20));
		// override taken at the cycle start: high forced on, low forced off
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c381);
		watch(10, 20);
		chk("synced override high", hc, 20);
		chk("synced override low", lc, 0);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c000);
		// fuse is synchronised inside, so let it settle before the locked write
		fuse <= 1'b1;
		repeat (4) @(posedge clk);
		wbx(1, OFS_OUTPUT_CONTROL, 0);
		wbx(0, OFS_OUTPUT_CONTROL, 0);
		chk("locked write", q, 32'h0000_c000);
		wbx(1, OFS_UNLOCK, UNLOCK_KEY_A);
		wbx(1, OFS_UNLOCK, UNLOCK_KEY_B);
		wbx(1, OFS_OUTPUT_CONTROL, 32'h0000_c400);
		wbx(0, OFS_OUTPUT_CONTROL, 0);
		chk("unlocked write", q, 32'h0000_c400);
		wbx(1, OFS_OUTPUT_CONTROL, 0);
		wbx(0, OFS_OUTPUT_CONTROL, 0);
		chk("relocked", q, 32'h0000_c400);
		stop_test();
	end
endmodule : tb_pwg_top
